// ### core/rx_config_bank.sv
/*
  Configuration bank for registers 0 to 15 of the receiver: calibration
  start, readback validity, power-down test defaults, gain and frequency
  loop settings, threshold lock, tuning enable and the test DAC.
  Assumes a single-cycle register master and readback and demodulator
  inputs that come from logic on CLK_I.
*/
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "rxcal_regs.svh"
module rx_config_bank
  import rxcal_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic [7:0] STRENGTH_I,
  input wire logic [7:0] BATT_I,
  input wire logic [7:0] TEMP_I,
  input wire logic [7:0] PIN_I,
  input wire logic [15:0] FREQ_I,
  input wire logic STRENGTH_SETTLED_FLAG_I,
  input wire logic [15:0] LIN_DEMOD_I,
  input wire logic [15:0] COR_DEMOD_I,
  output logic RX_MODE_O,
  output logic MUX_O,
  output logic CAL_BUSY_O,
  output logic CAL_TONE_O,
  output logic [5:0] FILTER_TRIM_O,
  output logic ADC_POWER_O,
  output logic TRX_SWITCH_EN_O,
  output agc_t AGC_O,
  output logic [7:0] FREQ_CORRECTION_RANGE_O,
  output logic [3:0] LOOP_INTEGRAL_GAIN_O,
  output logic [2:0] LOOP_PROPORTIONAL_GAIN_O,
  output logic THRESHOLD_FREEZE_O,
  output tune_t TUNE_O,
  output logic TUNE_EN_O,
  output logic DAC_EN_O,
  output logic RECOVERY_ACTIVE_O,
  output logic SEQUENCER_TICK_O,
  output logic SYNC_DETECT_O
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  core_reg_t s_r;
  core_reg_t s_nxt;
  logic rx;
  logic cal_start;
  logic cal_busy;
  logic cal_done;
  logic cal_tone;
  logic rb_valid;
  logic [15:0] rb_val;
  logic [15:0] dac_sel;
  logic signed [26:0] dac_wide;
  logic [7:0] cdr_div;

  // Divider wrap test, shared by the three clock enables.
  function automatic logic div_last(input logic [7:0] cnt, input logic [7:0] div);
    div_last = (div == 8'h00) || (cnt == div - 8'h01);
  endfunction : div_last

  assign rx = s_r.regs[`REG_CTRL][`TXRX_BIT];
  assign cdr_div = s_r.regs[`REG_CLK][`CDRDIV_LSB +: 8];
  assign cal_start = WR_I && (ADDR_I == `REG_IFCAL) && WDATA_I[`COARSE_BIT];

  // ----------------------------------------------------------------------
  // Readback selection
  // ----------------------------------------------------------------------
  always_comb begin
    rb_val = 16'h0000;
    rb_valid = 1'b0;
    case (rb_sel_t'(s_r.regs[`REG_RB][`RBSEL_LSB +: 3]))
      RB_STRENGTH: begin
        rb_val = {8'h00, STRENGTH_I};
        rb_valid = rx;
      end
      RB_BATT: begin
        rb_val = {8'h00, BATT_I};
        rb_valid = !rx && s_r.adc_pwr;
      end
      RB_TEMP: begin
        rb_val = {8'h00, TEMP_I};
        rb_valid = !rx && s_r.adc_pwr;
      end
      RB_PIN: begin
        rb_val = {8'h00, PIN_I};
        rb_valid = !rx && s_r.adc_pwr;
      end
      RB_FREQ: begin
        rb_val = FREQ_I;
        rb_valid = 1'b1;
      end
      default: begin
        rb_val = 16'h0000;
        rb_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Test DAC input path
  // ----------------------------------------------------------------------
  // The difference is widened before the gain shift and then clipped, so a large
  // gain saturates instead of folding over.
  always_comb begin
    dac_sel = s_r.regs[`REG_DAC][`DACSEL_BIT] ? COR_DEMOD_I : LIN_DEMOD_I;
    dac_wide = ({{11{dac_sel[15]}}, dac_sel}
      - {{17{s_r.regs[`REG_DAC][`OFS_LSB + 9]}}, s_r.regs[`REG_DAC][`OFS_LSB +: 10]})
      <<< s_r.regs[`REG_DAC][`DGAIN_LSB +: 3];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0000_0000;
    if (WR_I) begin
      s_nxt.regs[ADDR_I] = WDATA_I;
    end
    if (RD_I) begin
      if (ADDR_I == `REG_RB) begin
        s_nxt.rdata = {rb_valid, cal_done, cal_busy, 13'h0000, rb_val};
      end else begin
        s_nxt.rdata = s_r.regs[ADDR_I];
      end
    end
    if (WR_I && (ADDR_I == `REG_DAC)) begin
      s_nxt.dac_en = 1'b1;
    end

    s_nxt.seq_tick = div_last(s_r.seq_cnt, s_r.regs[`REG_CLK][`SEQDIV_LSB +: 8]);
    s_nxt.seq_cnt = s_nxt.seq_tick ? 8'h00 : s_r.seq_cnt + 8'h01;
    s_nxt.dem_tick = div_last(s_r.dem_cnt, {4'h0, s_r.regs[`REG_CLK][`DEMDIV_LSB +: 4]});
    s_nxt.dem_cnt = s_nxt.dem_tick ? 8'h00 : s_r.dem_cnt + 8'h01;
    s_nxt.rec_tick = 1'b0;
    if (s_r.dem_tick) begin
      s_nxt.rec_tick = div_last(s_r.cdr_cnt, cdr_div);
      s_nxt.cdr_cnt = s_nxt.rec_tick ? 8'h00 : s_r.cdr_cnt + 8'h01;
    end
    // A divide of one or less puts the recovery clock at the demodulator rate.
    s_nxt.rec_ok = (cdr_div > 8'h01);

    s_nxt.rx_prev = rx;
    if (rx && !s_r.rx_prev) begin
      s_nxt.trim = s_r.regs[`REG_IFCAL][`TRIM_LSB +: 6];
    end

    if (dac_wide > 27'sh0007fff) begin
      s_nxt.dac_in = 16'h7fff;
    end else if (dac_wide < -27'sh0008000) begin
      s_nxt.dac_in = 16'h8000;
    end else begin
      s_nxt.dac_in = dac_wide[15:0];
    end

    case (s_r.regs[`REG_CTRL][`MUX_LSB +: 3])
      3'h0: s_nxt.mux = cal_done;
      3'h1: s_nxt.mux = STRENGTH_SETTLED_FLAG_I && rx;
      3'h2: s_nxt.mux = rx;
      default: s_nxt.mux = 1'b0;
    endcase

    s_nxt.adc_pwr = rx || s_r.regs[`REG_PDT][`ADC_PWR_BIT];
    s_nxt.trsw = !s_r.regs[`REG_PDT][`TRSW_BIT];

    s_nxt.agc.gain_low_limit = s_r.regs[`REG_AGC][`GLOW_LSB +: 7];
    s_nxt.agc.gain_high_limit = s_r.regs[`REG_AGC][`GHIGH_LSB +: 7];
    s_nxt.agc.auto_on = rx && (s_r.regs[`REG_AGC][`AGCMODE_LSB +: 2] == 2'h0);
    if (s_r.regs[`REG_AGC][`FAMODE_BIT]
        && (s_r.regs[`REG_AGC][`FGAIN_LSB +: 2] == `FRONT_GAIN_30)) begin
      s_nxt.agc.front_gain = `FRONT_GAIN_FALLBACK;
    end else begin
      s_nxt.agc.front_gain = s_r.regs[`REG_AGC][`FGAIN_LSB +: 2];
    end

    if (s_r.regs[`REG_OSC][`HALVE_BIT]) begin
      s_nxt.range = {1'b0, s_r.regs[`REG_AFC][`RANGE_LSB + 1 +: 7]};
    end else begin
      s_nxt.range = s_r.regs[`REG_AFC][`RANGE_LSB +: 8];
    end
    s_nxt.ki = s_r.regs[`REG_AFC][`KI_LSB +: 4];
    s_nxt.kp = s_r.regs[`REG_AFC][`KP_LSB +: 3];
    s_nxt.freeze = s_r.regs[`REG_THR][`TLOCK_BIT];

    s_nxt.tune_en = (s_r.regs[`REG_TEST][`TMODE_LSB +: 4] == `TMODE_TUNE);
    if (s_nxt.tune_en) begin
      s_nxt.tune.pulse_stretch_tuning = s_r.regs[`REG_DAC][`PULSE_LSB +: 2];
      s_nxt.tune.detector_leak_tuning = s_r.regs[`REG_DAC][`LEAK_LSB +: 3];
      s_nxt.tune.detector_peak_tuning = s_r.regs[`REG_DAC][`PEAK_LSB +: 2];
    end else begin
      s_nxt.tune = '0;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r <= '0;
      s_r.regs[`REG_AGC] <= `AGC_RST;
      s_r.agc.gain_low_limit <= `AGC_LOW_DEF;
      s_r.agc.gain_high_limit <= `AGC_HIGH_DEF;
      s_r.trsw <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration and test DAC
  // ----------------------------------------------------------------------
  filter_cal_seq u_cal (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .start_i(cal_start),
    .fine_en_i(s_r.regs[`REG_FINE][`FINE_EN_BIT]),
    .tick_i(s_r.seq_tick),
    .dwell_i(s_r.regs[`REG_FINE][`DWELL_LSB +: 8]),
    .busy_o(cal_busy),
    .done_o(cal_done),
    .tone_o(cal_tone)
  );

  sigma_delta_dac u_dac (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .en_i(s_r.dac_en),
    .tick_i(s_r.rec_tick),
    .din_i(s_r.dac_in),
    .bit_o(SYNC_DETECT_O)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RDATA_O = s_r.rdata;
  assign RX_MODE_O = s_r.rx_prev;
  assign MUX_O = s_r.mux;
  assign CAL_BUSY_O = cal_busy;
  assign CAL_TONE_O = cal_tone;
  assign FILTER_TRIM_O = s_r.trim;
  assign ADC_POWER_O = s_r.adc_pwr;
  assign TRX_SWITCH_EN_O = s_r.trsw;
  assign AGC_O = s_r.agc;
  assign FREQ_CORRECTION_RANGE_O = s_r.range;
  assign LOOP_INTEGRAL_GAIN_O = s_r.ki;
  assign LOOP_PROPORTIONAL_GAIN_O = s_r.kp;
  assign THRESHOLD_FREEZE_O = s_r.freeze;
  assign TUNE_O = s_r.tune;
  assign TUNE_EN_O = s_r.tune_en;
  assign DAC_EN_O = s_r.dac_en;
  assign RECOVERY_ACTIVE_O = s_r.rec_ok;
  assign SEQUENCER_TICK_O = s_r.seq_tick;
endmodule : rx_config_bank

// ### core/rxcal_regs.svh
/*
  Register indices, field positions, reset values and timing counts of the
  receiver calibration, readback and configuration bank.
  Assumes it is included by bare name wherever these figures are needed.
*/
`ifndef RXCAL_REGS_SVH
`define RXCAL_REGS_SVH
// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_OSC 4'h1
`define REG_CLK 4'h3
`define REG_IFCAL 4'h5
`define REG_FINE 4'h6
`define REG_RB 4'h7
`define REG_PDT 4'h8
`define REG_AGC 4'h9
`define REG_AFC 4'ha
`define REG_THR 4'hc
`define REG_DAC 4'he
`define REG_TEST 4'hf
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TXRX_BIT 27
`define MUX_LSB 29
`define HALVE_BIT 18
`define SEQDIV_LSB 4
`define DEMDIV_LSB 12
`define CDRDIV_LSB 16
`define COARSE_BIT 4
`define TRIM_LSB 14
`define FINE_EN_BIT 4
`define DWELL_LSB 5
`define RBSEL_LSB 4
`define ADC_PWR_BIT 8
`define TRSW_BIT 11
`define GLOW_LSB 4
`define GHIGH_LSB 11
`define AGCMODE_LSB 18
`define FGAIN_LSB 20
`define FAMODE_BIT 25
`define KI_LSB 4
`define KP_LSB 8
`define RANGE_LSB 24
`define TLOCK_BIT 4
`define DACSEL_BIT 4
`define OFS_LSB 5
`define DGAIN_LSB 15
`define PULSE_LSB 18
`define LEAK_LSB 20
`define PEAK_LSB 23
`define TMODE_LSB 4
// ----------------------------------------------------------------------
// Values and counts
// ----------------------------------------------------------------------
`define TMODE_TUNE 4'h9
`define AGC_LOW_DEF 7'h1e
`define AGC_HIGH_DEF 7'h46
`define AGC_RST {14'h0000, `AGC_HIGH_DEF, `AGC_LOW_DEF, `REG_AGC}
`define FRONT_GAIN_30 2'h3
`define FRONT_GAIN_FALLBACK 2'h2
`define COARSE_TONES 4'h1
`define FINE_TONES 4'ha
`define CLK_HZ 25000000
`define TONE_MIN_US 500
`define TONE_MIN_CYC ((`TONE_MIN_US * `CLK_HZ + 999999) / 1000000)
`define SDM_FULL 20'sh08000
`endif

// ### core/rxcal_pkg.sv
/*
  Types shared by the configuration bank and its calibration and test DAC
  blocks. Assumes rxcal_regs.svh is compiled alongside.
*/
package rxcal_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_COARSE, CAL_FINE} cal_state_t;
  typedef enum logic [2:0] {RB_STRENGTH, RB_BATT, RB_TEMP, RB_PIN, RB_FREQ} rb_sel_t;
  typedef struct packed {
    logic [1:0] pulse_stretch_tuning;
    logic [2:0] detector_leak_tuning;
    logic [1:0] detector_peak_tuning;
  } tune_t;
  typedef struct packed {
    logic [6:0] gain_low_limit;
    logic [6:0] gain_high_limit;
    logic auto_on;
    logic [1:0] front_gain;
  } agc_t;
  typedef struct packed {
    cal_state_t st;
    logic fine;
    logic [7:0] cnt;
    logic [3:0] tones;
    logic done;
  } cal_reg_t;
  typedef struct packed {
    logic signed [19:0] e1;
    logic signed [19:0] e2;
    logic q;
  } sdm_reg_t;
  typedef struct packed {
    logic [15:0][31:0] regs;
    logic [31:0] rdata;
    logic [7:0] seq_cnt;
    logic seq_tick;
    logic [7:0] dem_cnt;
    logic dem_tick;
    logic [7:0] cdr_cnt;
    logic rec_tick;
    logic rec_ok;
    logic rx_prev;
    logic [5:0] trim;
    logic dac_en;
    logic [15:0] dac_in;
    logic mux;
    logic adc_pwr;
    logic trsw;
    agc_t agc;
    logic [7:0] range;
    logic [3:0] ki;
    logic [2:0] kp;
    logic freeze;
    tune_t tune;
    logic tune_en;
  } core_reg_t;
endpackage : rxcal_pkg

// ### core/filter_cal_seq.sv
/*
  IF filter calibration sequencer: a coarse step, then optionally ten fine
  tone intervals, each a programmed number of sequencer ticks.
  Assumes start_i and tick_i are one-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
`include "rxcal_regs.svh"
module filter_cal_seq
  import rxcal_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic fine_en_i,
  input wire logic tick_i,
  input wire logic [7:0] dwell_i,
  output logic busy_o,
  output logic done_o,
  output logic tone_o
);
  cal_reg_t s_r;
  cal_reg_t s_nxt;
  logic last;

  always_comb begin
    s_nxt = s_r;
    last = (dwell_i == 8'h00) || (s_r.cnt == dwell_i - 8'h01);
    if (start_i) begin
      // A new request always restarts from the coarse step.
      s_nxt.st = CAL_COARSE;
      s_nxt.fine = fine_en_i;
      s_nxt.cnt = 8'h00;
      s_nxt.tones = 4'h0;
      s_nxt.done = 1'b0;
    end else if (tick_i) begin
      case (s_r.st)
        CAL_IDLE: begin
          s_nxt.cnt = 8'h00;
        end
        CAL_COARSE: begin
          s_nxt.cnt = last ? 8'h00 : s_r.cnt + 8'h01;
          if (last && (s_r.tones + 4'h1 == `COARSE_TONES)) begin
            s_nxt.tones = 4'h0;
            s_nxt.st = s_r.fine ? CAL_FINE : CAL_IDLE;
            s_nxt.done = !s_r.fine;
          end else if (last) begin
            s_nxt.tones = s_r.tones + 4'h1;
          end
        end
        CAL_FINE: begin
          s_nxt.cnt = last ? 8'h00 : s_r.cnt + 8'h01;
          if (last && (s_r.tones + 4'h1 == `FINE_TONES)) begin
            s_nxt.tones = 4'h0;
            s_nxt.st = CAL_IDLE;
            s_nxt.done = 1'b1;
          end else if (last) begin
            s_nxt.tones = s_r.tones + 4'h1;
          end
        end
        default: begin
          s_nxt.st = CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_o = (s_r.st != CAL_IDLE);
  assign done_o = s_r.done;
  assign tone_o = s_r.tones[0];
endmodule : filter_cal_seq

// ### core/sigma_delta_dac.sv
/*
  Second-order error-feedback sigma-delta modulator for the test DAC.
  Assumes tick_i is the one-cycle recovery clock enable on clk_i.
*/
`timescale 1ns/1ps
`include "rxcal_regs.svh"
module sigma_delta_dac
  import rxcal_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic [15:0] din_i,
  output logic bit_o
);
  sdm_reg_t s_r;
  sdm_reg_t s_nxt;
  logic signed [19:0] u;

  always_comb begin
    s_nxt = s_r;
    // Twenty bits keep u clear of wrap with the doubled error term.
    u = {{4{din_i[15]}}, din_i} + (s_r.e1 <<< 1) - s_r.e2;
    if (!en_i) begin
      s_nxt = '0;
    end else if (tick_i) begin
      s_nxt.q = !u[19];
      s_nxt.e2 = s_r.e1;
      s_nxt.e1 = u[19] ? u + `SDM_FULL : u - `SDM_FULL;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bit_o = s_r.q;
endmodule : sigma_delta_dac

// ### tb/rx_config_bank_assertions.sv
/*
  Port checker for the receiver configuration bank.
  Assumes it is bound to rx_config_bank and sees only its ports.
*/
`timescale 1ns/1ps
module rx_config_bank_assertions
  import rxcal_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic CAL_BUSY_O,
  input wire logic ADC_POWER_O,
  input wire logic TRX_SWITCH_EN_O,
  input wire agc_t AGC_O,
  input wire logic THRESHOLD_FREEZE_O,
  input wire tune_t TUNE_O,
  input wire logic TUNE_EN_O,
  input wire logic DAC_EN_O,
  input wire logic SYNC_DETECT_O
);
  // ----------------------------------------------------------------
  // Write decodes
  // ----------------------------------------------------------------
  logic w5, w6, w8, w9, w12, w14;
  assign w5 = WR_I && ADDR_I == 4'h5;
  assign w6 = WR_I && ADDR_I == 4'h6;
  assign w8 = WR_I && ADDR_I == 4'h8;
  assign w9 = WR_I && ADDR_I == 4'h9;
  assign w12 = WR_I && ADDR_I == 4'hc;
  assign w14 = WR_I && ADDR_I == 4'he;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_coarse_starts: assert property (w5 && WDATA_I[4] |=> CAL_BUSY_O)
    else $error("calibration did not start");
  a_fine_alone: assert property (w6 && !CAL_BUSY_O |=> !CAL_BUSY_O)
    else $error("fine enable alone started a calibration");
  a_adc_enable: assert property ((w8 && WDATA_I[8]) ##1 !w8 |=> ADC_POWER_O)
    else $error("converter not powered");
  a_switch_bit: assert property (w8 ##1 !w8 |=> TRX_SWITCH_EN_O == !$past(WDATA_I[11], 2))
    else $error("switch enable wrong");
  a_gain_fallback: assert property ((w9 && WDATA_I[25] && WDATA_I[21:20] == 2'h3) ##1 !w9
      |=> AGC_O.front_gain == 2'h2)
    else $error("gain 30 offered in amplifier mode one");
  a_freeze_lock: assert property (w12 ##1 !w12 |=> THRESHOLD_FREEZE_O == $past(WDATA_I[4], 2))
    else $error("threshold freeze wrong");
  a_tune_gated: assert property (!TUNE_EN_O |-> TUNE_O == '0)
    else $error("tuning fields applied while disabled");
  a_dac_enable: assert property (w14 |-> ##2 DAC_EN_O [*4])
    else $error("test converter not enabled");
  a_sync_quiet: assert property (!DAC_EN_O |-> !SYNC_DETECT_O)
    else $error("sync pin active while converter off");
  a_read_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data outside read cycle");
  c_restart: cover property (w5 && WDATA_I[4] && CAL_BUSY_O);
  c_cal_end: cover property ($fell(CAL_BUSY_O));
  c_stream: cover property (DAC_EN_O && SYNC_DETECT_O);
endmodule : rx_config_bank_assertions

bind rx_config_bank rx_config_bank_assertions i_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .CAL_BUSY_O(CAL_BUSY_O), .ADC_POWER_O(ADC_POWER_O),
  .TRX_SWITCH_EN_O(TRX_SWITCH_EN_O), .AGC_O(AGC_O), .THRESHOLD_FREEZE_O(THRESHOLD_FREEZE_O),
  .TUNE_O(TUNE_O), .TUNE_EN_O(TUNE_EN_O), .DAC_EN_O(DAC_EN_O), .SYNC_DETECT_O(SYNC_DETECT_O)
);

// ### tb/demod_source.sv
/*
  Model of the demodulator and readback sources beside the bank.
  Assumes the same clock and reset as the bank.
*/
`timescale 1ns/1ps
module demod_source (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [15:0] lin_o,
  output logic [15:0] cor_o,
  output logic settled_o
);
  // A shift register keeps every source moving, so no stale value can match by chance.
  logic [15:0] lfsr_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lfsr_r <= 16'hace1;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end
  assign lin_o = lfsr_r;
  assign cor_o = ~lfsr_r;
  assign settled_o = lfsr_r[0];
endmodule : demod_source

// ### tb/rx_config_bank_bench.sv
/*
  Self-checking bench of the receiver configuration bank.
  Assumes the bank, its package and the source model are compiled first.
*/
`timescale 1ns/1ps
`include "rxcal_regs.svh"
module rx_config_bank_bench
  import rxcal_pkg::*;
;
  logic CLK_I = 1'b0, RST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
  logic [3:0] ADDR_I = 4'h0;
  logic [31:0] WDATA_I = 32'h0, RDATA_O, rv, d;
  logic RX_MODE_O, MUX_O, CAL_BUSY_O, CAL_TONE_O, ADC_POWER_O, TRX_SWITCH_EN_O;
  logic THRESHOLD_FREEZE_O, TUNE_EN_O, DAC_EN_O, RECOVERY_ACTIVE_O, SEQUENCER_TICK_O;
  logic SYNC_DETECT_O, settled;
  logic [5:0] FILTER_TRIM_O;
  logic [7:0] FREQ_CORRECTION_RANGE_O, r;
  logic [3:0] LOOP_INTEGRAL_GAIN_O;
  logic [2:0] LOOP_PROPORTIONAL_GAIN_O;
  logic [15:0] lin, cor;
  logic [6:0] lo, hi, t;
  agc_t AGC_O;
  tune_t TUNE_O;
  int fail_count = 0, cmp_count = 0, n, dw;
  always #20 CLK_I = ~CLK_I;
  demod_source i_src (.clk_i(CLK_I), .rst_i(RST_I), .lin_o(lin), .cor_o(cor),
    .settled_o(settled));
  rx_config_bank i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .STRENGTH_I(lin[7:0]), .BATT_I(lin[15:8]),
    .TEMP_I(cor[7:0]), .PIN_I(cor[15:8]), .FREQ_I(lin), .STRENGTH_SETTLED_FLAG_I(settled),
    .LIN_DEMOD_I(lin), .COR_DEMOD_I(cor), .RX_MODE_O(RX_MODE_O), .MUX_O(MUX_O),
    .CAL_BUSY_O(CAL_BUSY_O), .CAL_TONE_O(CAL_TONE_O), .FILTER_TRIM_O(FILTER_TRIM_O),
    .ADC_POWER_O(ADC_POWER_O), .TRX_SWITCH_EN_O(TRX_SWITCH_EN_O), .AGC_O(AGC_O),
    .FREQ_CORRECTION_RANGE_O(FREQ_CORRECTION_RANGE_O),
    .LOOP_INTEGRAL_GAIN_O(LOOP_INTEGRAL_GAIN_O),
    .LOOP_PROPORTIONAL_GAIN_O(LOOP_PROPORTIONAL_GAIN_O),
    .THRESHOLD_FREEZE_O(THRESHOLD_FREEZE_O), .TUNE_O(TUNE_O), .TUNE_EN_O(TUNE_EN_O),
    .DAC_EN_O(DAC_EN_O), .RECOVERY_ACTIVE_O(RECOVERY_ACTIVE_O),
    .SEQUENCER_TICK_O(SEQUENCER_TICK_O), .SYNC_DETECT_O(SYNC_DETECT_O));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Tasks drive on a rising edge and return at a falling edge, so that every
  // output is looked at while it is settled.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= v;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
    @(negedge CLK_I);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    @(negedge CLK_I);
    v = RDATA_O;
  endtask : rd
  task automatic pass(input int c);
    repeat (c) @(posedge CLK_I);
    @(negedge CLK_I);
  endtask : pass
  // The sequencer divider is four; the tick phase leaves a few cycles of slack.
  function automatic int cal_len(input int fine, input int dwell);
    return (fine != 0 ? `FINE_TONES + `COARSE_TONES : `COARSE_TONES) * dwell * 4;
  endfunction : cal_len
  task automatic cal_wait(input int exp, input int used);
    n = used;
    while (CAL_BUSY_O === 1'b1 && n < 4000) begin
      @(negedge CLK_I);
      n++;
    end
    chk(n >= exp - 6 && n <= exp + 6, 1'b1);
  endtask : cal_wait
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rv = $urandom(48);
    pass(16);
    RST_I <= 1'b0;
    pass(1);
    rd(`REG_AGC, rv);
    chk(rv, `AGC_RST);
    chk(AGC_O, {`AGC_LOW_DEF, `AGC_HIGH_DEF, 3'h0});
    chk({TRX_SWITCH_EN_O, ADC_POWER_O}, 2'h2);
    $display("test reset defaults done");
    for (int i = 0; i < 12; i++) begin
      ADDR_I <= 4'h8 + 4'($urandom_range(7));
      d = $urandom;
      @(posedge CLK_I);
      wr(ADDR_I, d);
      rd(ADDR_I, rv);
      chk(rv, d);
    end
    $display("test register round trip done");
    wr(`REG_CLK, 32'h0002_1040);
    n = 0;
    repeat (40) begin
      @(negedge CLK_I);
      n += SEQUENCER_TICK_O;
    end
    chk(n, 10);
    for (int f = 0; f < 2; f++) begin
      dw = $urandom_range(5, 1);
      wr(`REG_FINE, {19'h0, 8'(dw), f[0], 4'h6});
      pass(4);
      chk(CAL_BUSY_O, 1'b0);
      wr(`REG_IFCAL, 32'h15);
      cal_wait(cal_len(f, dw), 1);
      rd(`REG_RB, rv);
      chk(rv[30], 1'b1);
      chk(MUX_O, 1'b1);
    end
    wr(`REG_IFCAL, 32'h15);
    pass(10);
    wr(`REG_IFCAL, 32'h15);
    rd(`REG_RB, rv);
    chk(rv[30:29], 2'h1);
    cal_wait(cal_len(1, dw), 3);
    $display("test calibration done");
    t = 7'($urandom);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_IFCAL, {12'h0, t[5:0], 14'h5});
    wr(`REG_CTRL, 32'h0800_0000);
    pass(3);
    chk({RX_MODE_O, FILTER_TRIM_O}, {1'b1, t[5:0]});
    wr(`REG_PDT, 32'h0000_0108);
    for (int s = 0; s < 8; s++) begin
      wr(`REG_CTRL, {4'h0, s[0], 27'h0});
      wr(`REG_RB, {25'h0, 3'(s >> 1), 4'h7});
      rd(`REG_RB, rv);
      chk(rv[31], s < 2 ? s[0] : !s[0]);
    end
    for (int v = 0; v < 4; v++) begin
      wr(`REG_CTRL, {4'h0, v[1], 27'h0});
      wr(`REG_PDT, {20'h0, v[0], 2'h0, v[0], 8'h8});
      pass(2);
      chk({ADC_POWER_O, TRX_SWITCH_EN_O}, {v[1] | v[0], !v[0]});
    end
    $display("test readback and power done");
    for (int m = 0; m < 2; m++) begin
      lo = 7'($urandom_range(40));
      hi = lo + 7'($urandom_range(40, 31));
      wr(`REG_AGC, {6'h0, m[0], 3'h0, `FRONT_GAIN_30, 2'h0, hi, lo, 4'h9});
      pass(2);
      chk(AGC_O, {lo, hi, 1'b1, m[0] ? `FRONT_GAIN_FALLBACK : `FRONT_GAIN_30});
      r = 8'($urandom);
      wr(`REG_OSC, {13'h0, m[0], 18'h1});
      wr(`REG_AFC, {r, 13'h0, 3'h4, 4'hb, 4'ha});
      pass(2);
      chk(FREQ_CORRECTION_RANGE_O, m[0] ? r >> 1 : r);
      chk({LOOP_INTEGRAL_GAIN_O, LOOP_PROPORTIONAL_GAIN_O}, 7'h5c);
      wr(`REG_THR, {27'h0, m[0], 4'hc});
      pass(2);
      chk(THRESHOLD_FREEZE_O, m[0]);
    end
    $display("test loop settings done");
    t = 7'($urandom);
    wr(`REG_DAC, {7'h0, t, 18'he});
    for (int m = 0; m < 16; m++) begin
      wr(`REG_TEST, {24'h0, 4'(m), 4'hf});
      pass(2);
      chk({TUNE_EN_O, TUNE_O}, m == 9 ? {1'b1, t[1:0], t[4:2], t[6:5]} : 8'h0);
    end
    chk({DAC_EN_O, RECOVERY_ACTIVE_O}, 2'h3);
    n = 0;
    repeat (400) begin
      @(negedge CLK_I);
      n += SYNC_DETECT_O;
    end
    chk(n > 0 && n < 400, 1'b1);
    wr(`REG_CLK, 32'h0001_1040);
    pass(2);
    chk(RECOVERY_ACTIVE_O, 1'b0);
    $display("test tuning and converter done");
    stop_test();
  end
endmodule : rx_config_bank_bench
